// >>> logic/mic_irq_ctrl.sv
// interrupt control: flags, enables, apb registers, vectoring, sleep wake-up
//
// Behaviour
// - fourteen sources, each with flag and enable
// - flags set regardless of any enable
// - global enable bit 7 gates all requests
// - enabled pending request vectors without software delay
// - reset clears global enable
// - entry clears global, pushes return, vectors 0004h
// - return op sets global enable again
// - external event to vector three-four instruction cycles
// - edge pin polarity from option bit 6
// - edge sets flag bit 1, enable bit 4
// - edge pin wakes sleep, global picks vector
// - timer rollover sets bit 2, enable 5
// - port pins 7:4 change sets bit 0
// - peripheral flags gated by group enable bit
// - entry saves only the return address
// - waking flag is what ends sleep
// - wake with global enable loads vector
// - wake ignores global; clear means continue sequentially
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module mic_irq_ctrl (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EDGE_IRQ_PIN,
	input wire logic [3:0] PORT_B_PINS,
	input wire logic TIMER_OVF,
	input wire logic [7:0] PERIPH_EVT_A,
	input wire logic [7:0] PERIPH_EVT_B,
	input wire logic SLEEP_OP,
	input wire logic RETURN_OP,
	input wire logic [12:0] RESUME_PC,
	output logic CORE_IRQ,
	output logic INSN_FLUSH,
	output logic PC_LOAD,
	output logic [12:0] PC_ADDR,
	output logic SLEEPING
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] ctrl_r; // irq_control_reg
	logic [7:0] ctrl_nxt;
	logic [7:0] pfa_r; // periph_flags_a
	logic [7:0] pfa_nxt;
	logic [7:0] pfb_r; // periph_flags_b
	logic [7:0] pfb_nxt;
	logic [7:0] pea_r; // periph_enables_a
	logic [7:0] peb_r; // periph_enables_b
	logic [7:0] opt_r; // option bits
	logic [1:0] div_r; // instruction-cycle divider
	logic tick; // one clock per instruction cycle
	logic edge_evt; // valid edge seen on the pin
	logic change_evt; // upper port pins changed
	logic periph_pend; // peripheral pair pending, group enable applied
	logic wake_req; // any enabled pending pair, global ignored
	logic irq_req; // request towards the core
	logic take; // request accepted this clock
	mic_pkg::mic_state_t state_r;
	logic sleeping_r;
	logic core_irq_r;
	logic flush_r;
	logic pc_load_r;
	logic [12:0] pc_addr_r;
	logic [12:0] top_addr; // last pushed return address
	logic acc; // apb access phase
	logic wr_done; // write takes effect this clock
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [31:0] rd_mux;
	logic rd_hit;

	// ----------------------------------------
	// pin front end and return stack
	// ----------------------------------------
	mic_pin_sync u_pins (
		.clk(CLK),
		.rst(RST),
		.pin_in(EDGE_IRQ_PIN),
		.port_in(PORT_B_PINS),
		.rising_sel(opt_r[mic_pkg::EDGE_SEL_BIT]),
		.edge_evt(edge_evt),
		.change_evt(change_evt)
	);

	// only the program counter goes on the stack
	mic_ret_stack u_stack (
		.clk(CLK),
		.rst(RST),
		.push(state_r == mic_pkg::S_FLUSH && tick),
		.pop(RETURN_OP),
		.push_addr(RESUME_PC),
		.top_addr(top_addr)
	);

	// ----------------------------------------
	// instruction-cycle divider
	// ----------------------------------------
	// one enable per four clocks; the sequencer steps on it, except S_VEC, which returns to idle after one clock
	always_ff @(posedge CLK) begin
		if (RST) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
	assign tick = (div_r == mic_pkg::INSN_DIV_LAST);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign acc = PSEL & PENABLE;
	// one wait state: the write lands on the edge that sees pready high
	assign wr_done = acc & pready_r & PWRITE;

	// read mux; reserved bits read zero
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case (PADDR)
			mic_pkg::OFF_CTRL: rd_mux[7:0] = ctrl_r;
			mic_pkg::OFF_PFA: rd_mux[7:0] = pfa_r;
			mic_pkg::OFF_PFB: rd_mux[7:0] = pfb_r;
			mic_pkg::OFF_PEA: rd_mux[7:0] = pea_r;
			mic_pkg::OFF_PEB: rd_mux[7:0] = peb_r;
			mic_pkg::OFF_OPT: rd_mux[7:0] = opt_r;
			mic_pkg::OFF_STAT: rd_mux[3:0] = {sleeping_r, flush_r, core_irq_r, wake_req};
			default: rd_hit = 1'b0;
		endcase
	end

	// handshake: answer in the second access clock, unmapped gives an error
	always_ff @(posedge CLK) begin
		if (RST) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= acc & ~pready_r;
			if (acc & ~pready_r) begin
				prdata_r <= PWRITE ? 32'h0 : rd_mux;
				pslverr_r <= ~rd_hit;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// plain software registers
	// ----------------------------------------
	// enables and options only change by bus write
	always_ff @(posedge CLK) begin
		if (RST) begin
			pea_r <= 8'h00;
			peb_r <= 8'h00;
			opt_r <= mic_pkg::OPT_RST;
		end else if (wr_done) begin
			// reserved enable bits are forced low
			if (PADDR == mic_pkg::OFF_PEA) pea_r <= PWDATA[7:0] & mic_pkg::PFA_MASK;
			if (PADDR == mic_pkg::OFF_PEB) peb_r <= PWDATA[7:0] & mic_pkg::PFB_MASK;
			if (PADDR == mic_pkg::OFF_OPT) opt_r <= PWDATA[7:0];
		end
	end

	// ----------------------------------------
	// flag and enable registers
	// ----------------------------------------
	// hardware sets win over a software clear in the same clock
	always_comb begin
		ctrl_nxt = ctrl_r;
		pfa_nxt = pfa_r;
		pfb_nxt = pfb_r;
		if (wr_done && PADDR == mic_pkg::OFF_CTRL) begin
			ctrl_nxt = PWDATA[7:0];
		end
		if (wr_done && PADDR == mic_pkg::OFF_PFA) begin
			pfa_nxt = PWDATA[7:0];
		end
		if (wr_done && PADDR == mic_pkg::OFF_PFB) begin
			pfb_nxt = PWDATA[7:0];
		end
		// flags never clear themselves; only software write clears them
		ctrl_nxt[mic_pkg::PIN_FLAG_BIT] = ctrl_nxt[mic_pkg::PIN_FLAG_BIT] | edge_evt;
		ctrl_nxt[mic_pkg::TIMER_FLAG_BIT] = ctrl_nxt[mic_pkg::TIMER_FLAG_BIT] | TIMER_OVF;
		ctrl_nxt[mic_pkg::PORT_FLAG_BIT] = ctrl_nxt[mic_pkg::PORT_FLAG_BIT] | change_evt;
		// peripheral events set flags no matter what any enable says
		pfa_nxt = (pfa_nxt | PERIPH_EVT_A) & mic_pkg::PFA_MASK;
		pfb_nxt = (pfb_nxt | PERIPH_EVT_B) & mic_pkg::PFB_MASK;
		// accepting clears the global enable to block nesting
		if (take) begin
			ctrl_nxt[mic_pkg::GLOBAL_EN_BIT] = 1'b0;
		end
		// return op re-enables; it wins over a same-clock bus write
		if (RETURN_OP) begin
			ctrl_nxt[mic_pkg::GLOBAL_EN_BIT] = 1'b1;
		end
	end

	// flag registers; reset leaves the global enable clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_r <= mic_pkg::CTRL_RST;
			pfa_r <= 8'h00;
			pfb_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			pfa_r <= pfa_nxt;
			pfb_r <= pfb_nxt;
		end
	end

	// ----------------------------------------
	// request combine
	// ----------------------------------------
	// peripheral pairs need the group enable as well
	assign periph_pend = ctrl_r[mic_pkg::GROUP_EN_BIT] & (|(pfa_r & pea_r) | |(pfb_r & peb_r));
	// wake-up looks at pairs only, never at the global enable
	assign wake_req = periph_pend
		| (ctrl_r[mic_pkg::PIN_FLAG_BIT] & ctrl_r[mic_pkg::PIN_EN_BIT])
		| (ctrl_r[mic_pkg::TIMER_FLAG_BIT] & ctrl_r[mic_pkg::TIMER_EN_BIT])
		| (ctrl_r[mic_pkg::PORT_FLAG_BIT] & ctrl_r[mic_pkg::PORT_EN_BIT]);
	// global enable gates the whole set
	assign irq_req = ctrl_r[mic_pkg::GLOBAL_EN_BIT] & wake_req;
	// accept at an instruction boundary while awake and idle
	assign take = irq_req & tick & ~sleeping_r & (state_r == mic_pkg::S_IDLE);

	// ----------------------------------------
	// vectoring sequencer
	// ----------------------------------------
	// sync one cycle, flush the fetched instruction, then vector;
	// the fixed flush makes latency the same for one- or two-cycle instructions
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= mic_pkg::S_IDLE;
		end else begin
			case (state_r)
				mic_pkg::S_IDLE: begin
					if (take) state_r <= mic_pkg::S_SYNC;
				end
				mic_pkg::S_SYNC: begin
					if (tick) state_r <= mic_pkg::S_FLUSH;
				end
				mic_pkg::S_FLUSH: begin
					if (tick) state_r <= mic_pkg::S_VEC;
				end
				mic_pkg::S_VEC: begin
					state_r <= mic_pkg::S_IDLE;
				end
				default: state_r <= mic_pkg::S_IDLE;
			endcase
		end
	end

	// program counter steering towards the core
	always_ff @(posedge CLK) begin
		if (RST) begin
			pc_load_r <= 1'b0;
			pc_addr_r <= 13'h0000;
		end else if (state_r == mic_pkg::S_VEC) begin
			pc_load_r <= 1'b1;
			pc_addr_r <= mic_pkg::IRQ_VECTOR;
		end else if (RETURN_OP) begin
			pc_load_r <= 1'b1;
			pc_addr_r <= top_addr;
		end else begin
			pc_load_r <= 1'b0;
		end
	end

	// core-facing levels, registered so outputs come from flops
	always_ff @(posedge CLK) begin
		if (RST) begin
			core_irq_r <= 1'b0;
			flush_r <= 1'b0;
		end else begin
			core_irq_r <= irq_req;
			flush_r <= (state_r == mic_pkg::S_FLUSH) | (state_r == mic_pkg::S_VEC);
		end
	end

	// ----------------------------------------
	// sleep and wake-up
	// ----------------------------------------
	// a pending pair turns sleep into a no-op; one arriving later wakes,
	// and with the global enable set the idle sequencer then vectors
	always_ff @(posedge CLK) begin
		if (RST) begin
			sleeping_r <= 1'b0;
		end else if (wake_req) begin
			sleeping_r <= 1'b0;
		end else if (SLEEP_OP) begin
			sleeping_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign CORE_IRQ = core_irq_r;
	assign INSN_FLUSH = flush_r;
	assign PC_LOAD = pc_load_r;
	assign PC_ADDR = pc_addr_r;
	assign SLEEPING = sleeping_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_global_reset: assert property (@(posedge CLK) RST |=> !ctrl_r[mic_pkg::GLOBAL_EN_BIT])
		else $error("global enable not cleared by reset");
	a_take_clears_global: assert property (@(posedge CLK) disable iff (RST)
		take && !RETURN_OP |=> !ctrl_r[mic_pkg::GLOBAL_EN_BIT])
		else $error("global enable still set after entry");
	a_vector_load: assert property (@(posedge CLK) disable iff (RST)
		take |-> ##10 (PC_LOAD && PC_ADDR == mic_pkg::IRQ_VECTOR))
		else $error("vector not loaded ten clocks after accept");
	a_return_global: assert property (@(posedge CLK) disable iff (RST)
		RETURN_OP |=> ctrl_r[mic_pkg::GLOBAL_EN_BIT] && PC_LOAD)
		else $error("return did not re-enable and load pc");
	a_timer_flag: assert property (@(posedge CLK) disable iff (RST)
		TIMER_OVF |=> ctrl_r[mic_pkg::TIMER_FLAG_BIT])
		else $error("timer flag lost");
	a_edge_flag: assert property (@(posedge CLK) disable iff (RST)
		edge_evt |=> ctrl_r[mic_pkg::PIN_FLAG_BIT])
		else $error("edge flag lost");
	a_global_blocks: assert property (@(posedge CLK) disable iff (RST)
		!ctrl_r[mic_pkg::GLOBAL_EN_BIT] |=> !CORE_IRQ)
		else $error("request passed with global enable clear");
	a_wake_sleep: assert property (@(posedge CLK) disable iff (RST)
		SLEEPING && wake_req |=> !SLEEPING)
		else $error("pending pair did not wake");
	// with the group gate shut and no core pair pending, peripheral pairs alone must not reach the core
	a_periph_gate: assert property (@(posedge CLK) disable iff (RST)
		!ctrl_r[mic_pkg::GROUP_EN_BIT] && !(ctrl_r[mic_pkg::PIN_FLAG_BIT] && ctrl_r[mic_pkg::PIN_EN_BIT])
		&& !(ctrl_r[mic_pkg::TIMER_FLAG_BIT] && ctrl_r[mic_pkg::TIMER_EN_BIT])
		&& !(ctrl_r[mic_pkg::PORT_FLAG_BIT] && ctrl_r[mic_pkg::PORT_EN_BIT]) |=> !CORE_IRQ)
		else $error("peripheral pair passed group gate");
endmodule

// >>> logic/mic_pkg.sv
// constants, field positions and state codes shared by the interrupt control block
package mic_pkg;
	// ----------------------------------------
	// register byte offsets on the apb bus
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00; // irq_control_reg
	localparam logic [7:0] OFF_PFA = 8'h04; // periph_flags_a
	localparam logic [7:0] OFF_PFB = 8'h08; // periph_flags_b
	localparam logic [7:0] OFF_PEA = 8'h0c; // periph_enables_a
	localparam logic [7:0] OFF_PEB = 8'h10; // periph_enables_b
	localparam logic [7:0] OFF_OPT = 8'h14; // option bits, edge polarity
	localparam logic [7:0] OFF_STAT = 8'h18; // read-only core status
	// ----------------------------------------
	// irq_control_reg field positions
	// ----------------------------------------
	localparam int GLOBAL_EN_BIT = 7; // global_irq_enable
	localparam int GROUP_EN_BIT = 6; // peripheral_group_enable
	localparam int TIMER_EN_BIT = 5; // timer_overflow_enable
	localparam int PIN_EN_BIT = 4; // edge_pin_enable
	localparam int PORT_EN_BIT = 3; // port_change_enable, kept apart from the pin enable
	localparam int TIMER_FLAG_BIT = 2; // timer_overflow_flag
	localparam int PIN_FLAG_BIT = 1; // edge_pin_flag
	localparam int PORT_FLAG_BIT = 0; // port_change_flag
	localparam int EDGE_SEL_BIT = 6; // edge_polarity_select in option register
	// ----------------------------------------
	// reset values and implemented-bit masks
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OPT_RST = 8'hff;
	localparam logic [7:0] PFA_MASK = 8'h7f; // bit 7 reserved
	localparam logic [7:0] PFB_MASK = 8'h0f; // upper bits reserved
	// ----------------------------------------
	// core sequencing
	// ----------------------------------------
	localparam int PC_W = 13;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;
	localparam logic [1:0] INSN_DIV_LAST = 2'h3; // four clocks per instruction cycle
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_SYNC = 4'b0010,
		S_FLUSH = 4'b0100,
		S_VEC = 4'b1000
	} mic_state_t;
endpackage

// >>> logic/mic_pin_sync.sv
// synchroniser and event detector for the edge pin and upper port pins
`timescale 1ns/100ps
module mic_pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_in,
	input wire logic [3:0] port_in,
	input wire logic rising_sel,
	output logic edge_evt,
	output logic change_evt
);
	// ----------------------------------------
	// two-stage synchronisers, then a history stage
	// ----------------------------------------
	logic pin_s1_r; // first stage, read only by stage two
	logic pin_s2_r;
	logic pin_d_r; // previous synchronised level
	logic [3:0] port_s1_r;
	logic [3:0] port_s2_r;
	logic [3:0] port_d_r;

	// sampling chain; history stage lets the detectors see only stable levels
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r <= 1'b0;
			port_s1_r <= 4'h0;
			port_s2_r <= 4'h0;
			port_d_r <= 4'h0;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
			port_s1_r <= port_in;
			port_s2_r <= port_s1_r;
			port_d_r <= port_s2_r;
		end
	end

	// polarity picks rising or falling; both come from stable stages
	assign edge_evt = rising_sel ? (pin_s2_r & ~pin_d_r) : (~pin_s2_r & pin_d_r);
	// any difference on the four pins is a change
	assign change_evt = |(port_s2_r ^ port_d_r);
endmodule

// >>> logic/mic_ret_stack.sv
// return-address stack, holds only the program counter
`timescale 1ns/100ps
module mic_ret_stack (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [12:0] push_addr,
	output logic [12:0] top_addr
);
	// ----------------------------------------
	// storage, circular like a real hardware stack
	// ----------------------------------------
	logic [12:0] mem_r [mic_pkg::STK_DEPTH]; // return addresses
	logic [2:0] ptr_r; // next free slot; wraps, overflow overwrites oldest

	// pointer moves on push or pop; push wins if both come together
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_r <= 3'h0;
		end else if (push) begin
			ptr_r <= ptr_r + 3'h1;
		end else if (pop) begin
			ptr_r <= ptr_r - 3'h1;
		end
	end

	// entries hold no reset: content is defined by the push that writes it
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[ptr_r] <= push_addr;
		end
	end

	// most recent entry sits one below the free slot
	assign top_addr = mem_r[ptr_r - 3'h1];
endmodule

// >>> verif/mic_core_model.sv
// behavioural model of the core sequencer and program counter facing the interrupt block
`timescale 1ns/100ps
module mic_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic pc_load,
	input wire logic [12:0] pc_addr,
	input wire logic insn_flush,
	input wire logic sleeping,
	input wire logic sleep_req,
	input wire logic ret_req,
	output logic sleep_op,
	output logic return_op,
	output logic [12:0] resume_pc
);
	logic [12:0] pc_r; // program counter
	logic [1:0] div_r; // clocks within one instruction cycle
	// ----------------------------------------
	// program counter
	// ----------------------------------------
	// pc holds still while flushing or asleep, so the pushed address is stable
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_r <= 13'h0000;
			div_r <= 2'h0;
		end else if (pc_load) begin
			pc_r <= pc_addr;
			div_r <= 2'h0;
		end else if (!insn_flush && !sleeping) begin
			div_r <= div_r + 2'h1;
			if (div_r == 2'h3) begin
				pc_r <= pc_r + 13'h0001;
			end
		end
	end
	// ----------------------------------------
	// instruction pulses
	// ----------------------------------------
	// one-clock pulses, launched just after an edge like a real sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_op <= 1'b0;
			return_op <= 1'b0;
		end else begin
			sleep_op <= sleep_req;
			return_op <= ret_req;
		end
	end
	assign resume_pc = pc_r;
endmodule

// >>> verif/tb_mic_irq_ctrl.sv
// self-checking testbench for the interrupt control block
`timescale 1ns/100ps
module tb_mic_irq_ctrl;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, pin, tovf;
	logic [7:0] paddr, evt_a, evt_b;
	logic [31:0] pwdata, prdata;
	logic [3:0] port;
	logic sleep_op, return_op, sleep_req, ret_req, core_irq, insn_flush, pc_load, sleeping, flush_d;
	logic [12:0] resume_pc, pc_addr, push_pc;
	int miscompares = 0, n_tests = 0, loads = 0, n, l0;
	// ----------------------------------------
	// design, core model and monitors
	// ----------------------------------------
	mic_irq_ctrl uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EDGE_IRQ_PIN(pin),
		.PORT_B_PINS(port), .TIMER_OVF(tovf), .PERIPH_EVT_A(evt_a), .PERIPH_EVT_B(evt_b), .SLEEP_OP(sleep_op),
		.RETURN_OP(return_op), .RESUME_PC(resume_pc), .CORE_IRQ(core_irq), .INSN_FLUSH(insn_flush),
		.PC_LOAD(pc_load), .PC_ADDR(pc_addr), .SLEEPING(sleeping));
	mic_core_model core (.clk(clk), .rst(rst), .pc_load(pc_load), .pc_addr(pc_addr), .insn_flush(insn_flush),
		.sleeping(sleeping), .sleep_req(sleep_req), .ret_req(ret_req), .sleep_op(sleep_op),
		.return_op(return_op), .resume_pc(resume_pc));
	// count pc loads, vector and return alike; note the address frozen once flushing starts
	always @(posedge clk) begin
		flush_d <= insn_flush;
		if (pc_load === 1'b1) loads <= loads + 1;
		if (insn_flush === 1'b1 && flush_d !== 1'b1) push_pc <= resume_pc;
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
			output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			miscompares++;
			close_out();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h000000, d}, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask
	// bounded wait for a pc load, vector or return; n is the count of edges waited
	task automatic wait_load();
		n = 0;
		while (pc_load !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			miscompares++;
			close_out();
		end
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, pin, tovf, sleep_req, ret_req} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		evt_a = 8'h00;
		evt_b = 8'h00;
		port = 4'h0;
		tick(10);
		rst <= 1'b0;
		@(posedge clk);
		rd(mic_pkg::OFF_CTRL, 32'h00, 1'b0);
		rd(mic_pkg::OFF_OPT, 32'hff, 1'b0);
		rd(8'h1c, 32'h0, 1'b1);
		endt("reset");
		// events with every enable clear still set flags, reserved bits stay clear
		tovf <= 1'b1;
		evt_a <= 8'hff;
		evt_b <= 8'hff;
		@(posedge clk);
		{tovf, evt_a, evt_b} <= 17'h0;
		tick(2);
		rd(mic_pkg::OFF_CTRL, 32'h04, 1'b0);
		rd(mic_pkg::OFF_PFA, 32'h7f, 1'b0);
		rd(mic_pkg::OFF_PFB, 32'h0f, 1'b0);
		chk({31'h0, core_irq}, 32'h0);
		wr(mic_pkg::OFF_PFA, 8'h00);
		wr(mic_pkg::OFF_PFB, 8'h00);
		wr(mic_pkg::OFF_CTRL, 8'h00);
		endt("flags");
		// pin polarity and port change
		pin <= 1'b1;
		tick(8);
		rd(mic_pkg::OFF_CTRL, 32'h02, 1'b0);
		wr(mic_pkg::OFF_CTRL, 8'h00);
		wr(mic_pkg::OFF_OPT, 8'h00);
		pin <= 1'b0;
		tick(8);
		rd(mic_pkg::OFF_CTRL, 32'h02, 1'b0);
		wr(mic_pkg::OFF_CTRL, 8'h00);
		pin <= 1'b1;
		port <= 4'h4;
		tick(8);
		rd(mic_pkg::OFF_CTRL, 32'h01, 1'b0);
		wr(mic_pkg::OFF_CTRL, 8'h90);
		endt("edges");
		// pin entry latency, vector, return
		pin <= 1'b0;
		@(posedge clk);
		wait_load();
		chk(n + 1, (n >= 12 && n <= 16) ? n + 1 : 32'h0);
		chk({19'h0, pc_addr}, {19'h0, mic_pkg::IRQ_VECTOR});
		chk({31'h0, insn_flush}, 32'h1);
		rd(mic_pkg::OFF_CTRL, 32'h12, 1'b0);
		wr(mic_pkg::OFF_CTRL, 8'h10);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		wait_load();
		chk({19'h0, pc_addr}, {19'h0, push_pc});
		rd(mic_pkg::OFF_CTRL, 32'h90, 1'b0);
		endt("entry");
		// peripheral request held back until the group enable is set
		wr(mic_pkg::OFF_CTRL, 8'h80);
		wr(mic_pkg::OFF_PEA, 8'h01);
		evt_a <= 8'h01;
		@(posedge clk);
		evt_a <= 8'h00;
		l0 = loads;
		tick(20);
		chk(loads, l0);
		wr(mic_pkg::OFF_CTRL, 8'hc0);
		wait_load();
		chk({19'h0, pc_addr}, {19'h0, mic_pkg::IRQ_VECTOR});
		wr(mic_pkg::OFF_PFA, 8'h00);
		wr(mic_pkg::OFF_CTRL, 8'h10);
		endt("group");
		// sleep, wake with global enable clear then set
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		tick(3);
		chk({31'h0, sleeping}, 32'h1);
		rd(mic_pkg::OFF_STAT, 32'h8, 1'b0);
		// pin already sits low: raise it first so that a falling edge can follow
		pin <= 1'b1;
		tick(4);
		pin <= 1'b0;
		n = 0;
		while (sleeping !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, sleeping}, 32'h0);
		l0 = loads;
		tick(20);
		chk(loads, l0);
		rd(mic_pkg::OFF_CTRL, 32'h12, 1'b0);
		wr(mic_pkg::OFF_CTRL, 8'h90);
		pin <= 1'b1;
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		tick(8);
		pin <= 1'b0;
		wait_load();
		chk({19'h0, pc_addr}, {19'h0, mic_pkg::IRQ_VECTOR});
		endt("sleep");
		close_out();
	end
endmodule
